// file: pxb_pkg.sv
package pxb_pkg;
  // geometry
  localparam int NUM_PORTS  = 2;
  localparam int NUM_PINS   = 16;
  localparam int NUM_FUNCS  = 26;
  localparam int FIRST_PRIO = 4;
  localparam int FIXED_BASE = 4;
  localparam int NUM_CEX    = 6;
  localparam logic [15:0] FIXED_MASK = 16'h00F0;
  // register addresses
  localparam logic [7:0] ADDR_ROUTE0 = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE1 = 8'hE2;
  localparam logic [7:0] ADDR_ROUTE2 = 8'hC7;
  localparam logic [7:0] ADDR_LATCH0 = 8'h80;
  localparam logic [7:0] ADDR_LATCH1 = 8'h90;
  localparam logic [7:0] ADDR_SKIP0  = 8'hD4;
  localparam logic [7:0] ADDR_SKIP1  = 8'hD5;
  localparam logic [7:0] ADDR_MDIN0  = 8'hF5;
  localparam logic [7:0] ADDR_MDIN1  = 8'hF6;
  localparam logic [7:0] ADDR_MDOUT0 = 8'hA4;
  localparam logic [7:0] ADDR_MDOUT1 = 8'hA5;
  // reset values and route2 write mask
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_SKIP  = 8'h00;
  localparam logic [7:0] RST_MDIN  = 8'hFF;
  localparam logic [7:0] RST_MDOUT = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] ROUTE2_WMASK = 8'hC1;
  // field positions
  localparam int R0_UART = 0;
  localparam int R0_CAN  = 1;
  localparam int R0_SPI  = 2;
  localparam int R0_SMB  = 3;
  localparam int R0_CP0  = 4;
  localparam int R0_CP0A = 5;
  localparam int R0_CP1  = 6;
  localparam int R0_CP1A = 7;
  localparam int R1_SYSCK  = 1;
  localparam int R1_CNT_LO = 2;
  localparam int R1_CNT_HI = 4;
  localparam int R1_ECI    = 5;
  localparam int R1_T0     = 6;
  localparam int R1_T1     = 7;
  localparam int R2_LIN  = 0;
  localparam int R2_XBAR = 6;
  localparam int R2_PUD  = 7;
  localparam int SS_FOUR_WIRE = 1;
  // function indices, priority order
  localparam int F_UTX  = 0;
  localparam int F_URX  = 1;
  localparam int F_CTX  = 2;
  localparam int F_CRX  = 3;
  localparam int F_SCK  = 4;
  localparam int F_MISO = 5;
  localparam int F_MOSI = 6;
  localparam int F_SS   = 7;
  localparam int F_SDA  = 8;
  localparam int F_SCL  = 9;
  localparam int F_CP0  = 10;
  localparam int F_CP0A = 11;
  localparam int F_CP1  = 12;
  localparam int F_CP1A = 13;
  localparam int F_SYSC = 14;
  localparam int F_COUNTER_MODULE_IO = 15;
  localparam int F_ECI  = 21;
  localparam int F_T0   = 22;
  localparam int F_T1   = 23;
  localparam int F_LTX  = 24;
  localparam int F_LRX  = 25;

  typedef logic [4:0] pxb_func_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pxb_sfr_req_t;
endpackage : pxb_pkg

// file: pxb_prio_decode.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_prio_decode (
  // configuration
  input  wire logic                          route_on,
  input  wire logic [pxb_pkg::NUM_FUNCS-1:0] func_en,
  input  wire logic [pxb_pkg::NUM_PINS-1:0]  skip,
  // pin assignment
  output logic [pxb_pkg::NUM_PINS-1:0]       used,
  output pxb_pkg::pxb_func_t [pxb_pkg::NUM_PINS-1:0] sel
);
  import pxb_pkg::*;

  logic found;

  always_comb begin
    used  = '0;
    sel   = '0;
    found = 1'b0;
    if (route_on) begin
      // fixed pins ignore skip bits
      for (int f = 0; f < FIRST_PRIO; f++) begin
        if (func_en[f]) begin
          used[FIXED_BASE + f] = 1'b1;
          sel[FIXED_BASE + f]  = pxb_func_t'(f);
        end
      end
      // lowest free, unskipped pin per enabled function
      for (int f = FIRST_PRIO; f < NUM_FUNCS; f++) begin
        found = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
          if (func_en[f] && !found && !skip[p] && !used[p]) begin
            used[p] = 1'b1;
            sel[p]  = pxb_func_t'(f);
            found   = 1'b1;
          end
        end
      end
    end
  end
endmodule : pxb_prio_decode
`default_nettype wire

// file: pxb_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_pin_cell (
  // mode
  input  wire logic route_on,
  input  wire logic digital,
  input  wire logic push_pull,
  input  wire logic force_od,
  input  wire logic pullup_dis,
  // drive request
  input  wire logic drive_req,
  input  wire logic drive_val,
  // pad controls
  output logic      out_val,
  output logic      out_en,
  output logic      pull_en,
  output logic      rx_en
);
  logic od;
  logic drive;

  always_comb begin
    od    = force_od || !push_pull;
    drive = route_on && digital && drive_req;
    rx_en = digital;
    if (od) begin
      out_val = 1'b0;
      out_en  = drive && !drive_val;
    end else begin
      out_val = drive_val;
      out_en  = drive;
    end
    // no pullup on analog, push-pull or a pin held low
    pull_en = digital && od && !pullup_dis && !(out_en && !out_val);
  end
endmodule : pxb_pin_cell
`default_nettype wire

// file: pxb_port_crossbar.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_port_crossbar (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          resetn,
  // register access
  input  wire pxb_pkg::pxb_sfr_req_t         sfr_req,
  output var  logic [7:0]                    sfr_rdata,
  // peripheral side
  input  wire logic [1:0]                    slave_select_mode_bits,
  input  wire logic [pxb_pkg::NUM_FUNCS-1:0] periph_out,
  input  wire logic [pxb_pkg::NUM_FUNCS-1:0] periph_oe,
  output var  logic [pxb_pkg::NUM_FUNCS-1:0] periph_in,
  // pads
  input  wire logic [pxb_pkg::NUM_PINS-1:0]  pin_in,
  output var  logic [pxb_pkg::NUM_PINS-1:0]  pin_out,
  output var  logic [pxb_pkg::NUM_PINS-1:0]  pin_oe,
  output var  logic [pxb_pkg::NUM_PINS-1:0]  pin_pullup
);
  import pxb_pkg::*;

  logic [7:0]                route0;
  logic [7:0]                route1;
  logic [7:0]                route2;
  logic [NUM_PORTS-1:0][7:0] skip;
  logic [NUM_PORTS-1:0][7:0] mdin;
  logic [NUM_PORTS-1:0][7:0] mdout;
  logic [NUM_PORTS-1:0][7:0] latch;
  logic [NUM_PINS-1:0]       skip_v;
  logic [NUM_PINS-1:0]       mdin_v;
  logic [NUM_PINS-1:0]       mdout_v;
  logic [NUM_PINS-1:0]       latch_v;
  logic [NUM_PORTS-1:0]      hit_skip;
  logic [NUM_PORTS-1:0]      hit_mdin;
  logic [NUM_PORTS-1:0]      hit_mdout;
  logic [NUM_PORTS-1:0]      hit_latch;
  logic [NUM_PINS-1:0]       pin_meta;
  logic [NUM_PINS-1:0]       pin_sync;
  logic [NUM_PINS-1:0]       pin_seen;
  logic [NUM_PINS-1:0]       rx_en;
  logic [NUM_PINS-1:0]       used;
  logic [NUM_PINS-1:0]       next_out;
  logic [NUM_PINS-1:0]       next_oe;
  logic [NUM_PINS-1:0]       next_pu;
  pxb_func_t [NUM_PINS-1:0]  sel;
  logic [NUM_FUNCS-1:0]      func_en;
  logic [NUM_FUNCS-1:0]      next_periph_in;
  logic [7:0]                next_rdata;
  logic [2:0]                cex_count;
  logic                      xbar_on;
  logic                      pullup_dis;
  logic                      four_wire;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // one-hot per port decode of an address pair
  function automatic logic [1:0] port_hit(
    input logic [7:0] a,
    input logic [7:0] base0,
    input logic [7:0] base1
  );
    port_hit = {a == base1, a == base0};
  endfunction : port_hit

  assign hit_skip  = port_hit(sfr_req.addr, ADDR_SKIP0, ADDR_SKIP1);
  assign hit_mdin  = port_hit(sfr_req.addr, ADDR_MDIN0, ADDR_MDIN1);
  assign hit_mdout = port_hit(sfr_req.addr, ADDR_MDOUT0, ADDR_MDOUT1);
  assign hit_latch = port_hit(sfr_req.addr, ADDR_LATCH0, ADDR_LATCH1);

  assign skip_v  = skip;
  assign mdin_v  = mdin;
  assign mdout_v = mdout;
  assign latch_v = latch;

  assign xbar_on    = route2[R2_XBAR];
  assign pullup_dis = route2[R2_PUD];
  assign four_wire  = slave_select_mode_bits[SS_FOUR_WIRE];

  // routing control registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      route0 <= RST_ROUTE;
      route1 <= RST_ROUTE;
      route2 <= RST_ROUTE;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_ROUTE0)
        route0 <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_ROUTE1)
        route1 <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_ROUTE2)
        route2 <= sfr_req.wdata & ROUTE2_WMASK;
    end
  end

  // per-port skip, mode and latch registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skip  <= {NUM_PORTS{RST_SKIP}};
      mdin  <= {NUM_PORTS{RST_MDIN}};
      mdout <= {NUM_PORTS{RST_MDOUT}};
      latch <= {NUM_PORTS{RST_LATCH}};
    end else if (sfr_req.wr) begin
      for (int n = 0; n < NUM_PORTS; n++) begin
        if (hit_skip[n])
          skip[n] <= sfr_req.wdata;
        if (hit_mdin[n])
          mdin[n] <= sfr_req.wdata;
        if (hit_mdout[n])
          mdout[n] <= sfr_req.wdata;
        if (hit_latch[n])
          latch[n] <= sfr_req.wdata;
      end
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_req.addr == ADDR_ROUTE0)
      next_rdata = route0;
    if (sfr_req.addr == ADDR_ROUTE1)
      next_rdata = route1;
    if (sfr_req.addr == ADDR_ROUTE2)
      next_rdata = route2;
    for (int n = 0; n < NUM_PORTS; n++) begin
      if (hit_skip[n])
        next_rdata = skip[n];
      if (hit_mdin[n])
        next_rdata = mdin[n];
      if (hit_mdout[n])
        next_rdata = mdout[n];
      if (hit_latch[n])
        next_rdata = pin_seen[n*8 +: 8];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= next_rdata;
  end

  // function enables from the routing registers
  always_comb begin
    cex_count = route1[R1_CNT_HI:R1_CNT_LO];
    func_en   = '0;
    func_en[F_UTX]  = route0[R0_UART];
    func_en[F_URX]  = route0[R0_UART];
    func_en[F_CTX]  = route0[R0_CAN];
    func_en[F_CRX]  = route0[R0_CAN];
    func_en[F_SCK]  = route0[R0_SPI];
    func_en[F_MISO] = route0[R0_SPI];
    func_en[F_MOSI] = route0[R0_SPI];
    func_en[F_SS]   = route0[R0_SPI] && four_wire;
    func_en[F_SDA]  = route0[R0_SMB];
    func_en[F_SCL]  = route0[R0_SMB];
    func_en[F_CP0]  = route0[R0_CP0];
    func_en[F_CP0A] = route0[R0_CP0A];
    func_en[F_CP1]  = route0[R0_CP1];
    func_en[F_CP1A] = route0[R0_CP1A];
    func_en[F_SYSC] = route1[R1_SYSCK];
    // reserved code 111 behaves as all six modules
    for (int i = 0; i < NUM_CEX; i++) begin
      func_en[F_COUNTER_MODULE_IO + i] = cex_count > 3'(i);
    end
    func_en[F_ECI] = route1[R1_ECI];
    func_en[F_T0]  = route1[R1_T0];
    func_en[F_T1]  = route1[R1_T1];
    func_en[F_LTX] = route2[R2_LIN];
    func_en[F_LRX] = route2[R2_LIN];
  end

  // priority placement; disabled matrix leaves every pin unrouted
  pxb_prio_decode u_decode (
    .route_on (xbar_on),
    .func_en  (func_en),
    .skip     (skip_v),
    .used     (used),
    .sel      (sel)
  );

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic req;
    logic val;
    logic od_force;

    // routed pin follows its function, others follow the latch
    always_comb begin
      req      = 1'b1;
      val      = latch_v[p];
      od_force = 1'b0;
      if (used[p]) begin
        req      = periph_oe[sel[p]];
        val      = periph_out[sel[p]];
        od_force = sel[p] == pxb_func_t'(F_SDA) ||
                   sel[p] == pxb_func_t'(F_SCL);
      end
    end

    pxb_pin_cell u_cell (
      .route_on   (xbar_on),
      .digital    (mdin_v[p]),
      .push_pull  (mdout_v[p]),
      .force_od   (od_force),
      .pullup_dis (pullup_dis),
      .drive_req  (req),
      .drive_val  (val),
      .out_val    (next_out[p]),
      .out_en     (next_oe[p]),
      .pull_en    (next_pu[p]),
      .rx_en      (rx_en[p])
    );

    a_smbus_opendrain: assert property (
      used[p] && (sel[p] == pxb_func_t'(F_SDA) ||
                  sel[p] == pxb_func_t'(F_SCL))
      |=> !(pin_oe[p] && pin_out[p]))
      else $error("two-wire pin driven high");

    a_slave_select_gate: assert property (
      used[p] && sel[p] == pxb_func_t'(F_SS)
      |-> route0[R0_SPI] && four_wire)
      else $error("slave select routed in three-wire mode");

    a_local_net_gate: assert property (
      used[p] && (sel[p] == pxb_func_t'(F_LTX) ||
                  sel[p] == pxb_func_t'(F_LRX))
      |-> route2[R2_LIN])
      else $error("local net routed while disabled");

    a_pullup_opendrain: assert property (
      mdin_v[p] && !mdout_v[p] && !pullup_dis && xbar_on
      && !used[p] && latch_v[p]
      |=> pin_pullup[p])
      else $error("open-drain pullup missing");
  end

  // pin inputs pass two flops before use
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign pin_seen = pin_sync & rx_en;

  // routed inputs to peripherals, idle high when unrouted
  always_comb begin
    next_periph_in = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (used[p])
        next_periph_in[sel[p]] = pin_seen[p];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      periph_in <= '1;
    else
      periph_in <= next_periph_in;
  end

  // registered pad controls
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_pullup <= '0;
    end else begin
      pin_out    <= next_out;
      pin_oe     <= next_oe;
      pin_pullup <= next_pu;
    end
  end

  a_uart_fixed_pins: assert property (
    xbar_on && route0[R0_UART]
    |-> used[FIXED_BASE + F_UTX] && used[FIXED_BASE + F_URX]
        && sel[FIXED_BASE + F_UTX] == pxb_func_t'(F_UTX)
        && sel[FIXED_BASE + F_URX] == pxb_func_t'(F_URX))
    else $error("serial pins not on fixed pins");

  a_can_fixed_pins: assert property (
    xbar_on && route0[R0_CAN]
    |-> used[FIXED_BASE + F_CTX] && used[FIXED_BASE + F_CRX]
        && sel[FIXED_BASE + F_CTX] == pxb_func_t'(F_CTX)
        && sel[FIXED_BASE + F_CRX] == pxb_func_t'(F_CRX))
    else $error("vehicle bus pins not on fixed pins");

  a_skip_honoured: assert property (
    (used & skip_v & ~FIXED_MASK) == '0)
    else $error("skipped pin received a function");

  a_matrix_off_quiet: assert property (
    !xbar_on |=> pin_oe == '0 && $past(used) == '0)
    else $error("pin driven with matrix disabled");

  a_analog_quiet: assert property (
    1'b1 |=> ((pin_oe | pin_pullup) & ~$past(mdin_v)) == '0)
    else $error("analog pin driven or pulled up");

  a_pullup_low_off: assert property (
    (pin_pullup & pin_oe & ~pin_out) == '0)
    else $error("pullup on while driving low");

  a_route0_write: assert property (
    sfr_req.wr && sfr_req.addr == ADDR_ROUTE0
    |=> route0 == $past(sfr_req.wdata) ##1
        (!$past(sfr_req.rd) || sfr_rdata == $past(next_rdata)))
    else $error("control0 write not taken");

  a_route2_resvd: assert property (
    (route2 & ~ROUTE2_WMASK) == 8'h00)
    else $error("control2 reserved bits set");

  a_cex_count: assert property (
    func_en[F_COUNTER_MODULE_IO +: NUM_CEX] ==
    NUM_CEX'((32'h1 << route1[R1_CNT_HI:R1_CNT_LO]) - 32'h1))
    else $error("counter module count decode wrong");
endmodule : pxb_port_crossbar
`default_nettype wire

// file: pxb_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_pad_model (
  // clock
  input  wire logic        clock,
  // design pad controls
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pullup,
  // outside drivers
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  // wire level
  output var  logic [15:0] pin_level
);
  logic [15:0] float_pat = 16'hA5A5;

  // undriven pads wander every cycle
  always @(posedge clock) begin
    float_pat <= ~float_pat;
  end

  always_comb begin
    for (int p = 0; p < 16; p++) begin
      if (pin_oe[p]) begin
        pin_level[p] = pin_out[p];
      end else if (ext_en[p]) begin
        pin_level[p] = ext_val[p];
      end else if (pin_pullup[p]) begin
        pin_level[p] = 1'b1;
      end else begin
        pin_level[p] = float_pat[p];
      end
    end
  end
endmodule : pxb_pad_model
`default_nettype wire

// file: pxb_port_crossbar_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_port_crossbar_tb_top;
  import pxb_pkg::*;
  localparam time DLY = 10ns;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  pxb_sfr_req_t sfr_req = '0;
  logic [7:0]   sfr_rdata;
  logic [1:0]   ss_mode = 2'b00;
  logic [25:0]  po = '0;
  logic [25:0]  poe = '0;
  logic [25:0]  periph_in;
  logic [15:0]  pin_lvl, pin_out, pin_oe, pin_pullup;
  logic [15:0]  ext_en = '0;
  logic [15:0]  ext_val = '0;
  logic [7:0]   r0 = '0, r1 = '0, r2 = '0;
  logic [15:0]  skp = '0, mdi = '1, mdo = '0, lat = '1;
  int           fail_count = 0;
  int           checks = 0;

  always #50 clock = ~clock;

  pxb_port_crossbar dut (
    .clock                  (clock),
    .resetn                 (resetn),
    .sfr_req                (sfr_req),
    .sfr_rdata              (sfr_rdata),
    .slave_select_mode_bits (ss_mode),
    .periph_out             (po),
    .periph_oe              (poe),
    .periph_in              (periph_in),
    .pin_in                 (pin_lvl),
    .pin_out                (pin_out),
    .pin_oe                 (pin_oe),
    .pin_pullup             (pin_pullup)
  );

  pxb_pad_model pads (
    .clock      (clock),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .pin_pullup (pin_pullup),
    .ext_en     (ext_en),
    .ext_val    (ext_val),
    .pin_level  (pin_lvl)
  );

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_reg(input string what, input logic [7:0] e,
                         input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_vec(input string what, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_vec

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #DLY;
    sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    #DLY;
    sfr_req.wr = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #DLY;
    sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    #DLY;
    sfr_req.rd = 1'b0;
    d = sfr_rdata;
  endtask : sfr_rd

  task automatic check_all();
    int sel [16];
    int fen [26];
    int p, f, n, cnt;
    logic [15:0] eoe, eout, epu, lvl, known, epl, lmask;
    logic [7:0]  rd0, rd1;
    logic [25:0] epi, pmask;
    logic od, val, req;
    fen = '{default: 0};
    fen[0] = r0[0];
    fen[1] = r0[0];
    fen[2] = r0[1];
    fen[3] = r0[1];
    for (f = 4; f < 7; f++)
      fen[f] = r0[2];
    fen[F_SS] = r0[2] & ss_mode[SS_FOUR_WIRE];
    fen[F_SDA] = r0[3];
    fen[F_SCL] = r0[3];
    for (f = 0; f < 4; f++)
      fen[F_CP0 + f] = r0[4 + f];
    fen[F_SYSC] = r1[1];
    cnt = (r1[4:2] == 3'h7) ? 6 : int'(r1[4:2]);
    for (f = 0; f < 6; f++)
      fen[F_COUNTER_MODULE_IO + f] = (f < cnt);
    for (f = 0; f < 3; f++)
      fen[F_ECI + f] = r1[5 + f];
    fen[F_LTX] = r2[0];
    fen[F_LRX] = r2[0];
    sel = '{default: -1};
    if (r2[6]) begin
      if (fen[0]) begin
        sel[4] = F_UTX;
        sel[5] = F_URX;
      end
      if (fen[2]) begin
        sel[6] = F_CTX;
        sel[7] = F_CRX;
      end
      for (f = 4; f < 26; f++) begin
        n = 0;
        while (n < 16 && (skp[n] || sel[n] >= 0))
          n++;
        if (fen[f] != 0 && n < 16)
          sel[n] = f;
      end
    end
    epi = '1;
    pmask = '1;
    for (p = 0; p < 16; p++) begin
      f = sel[p];
      od = !mdo[p] || f == F_SDA || f == F_SCL;
      req = (f < 0) ? 1'b1 : poe[f];
      val = (f < 0) ? lat[p] : po[f];
      eoe[p] = r2[6] && mdi[p] && req && (!od || !val);
      eout[p] = !od && val;
      epu[p] = mdi[p] && od && !r2[7] && !(eoe[p] && !eout[p]);
      known[p] = eoe[p] || ext_en[p] || epu[p];
      lvl[p] = eoe[p] ? eout[p] : (ext_en[p] ? ext_val[p] : 1'b1);
      epl[p] = mdi[p] && lvl[p];
      lmask[p] = known[p] || !mdi[p];
      if (f >= 0) begin
        epi[f] = mdi[p] && lvl[p];
        pmask[f] = known[p] || !mdi[p];
      end
    end
    cmp_vec("pin_oe", eoe, pin_oe);
    cmp_vec("pin_out", eout & eoe, pin_out & eoe);
    cmp_vec("pin_pullup", epu, pin_pullup);
    cmp_vec("periph_in", epi & pmask, periph_in & pmask);
    sfr_rd(ADDR_LATCH0, rd0);
    sfr_rd(ADDR_LATCH1, rd1);
    cmp_vec("port read", epl & lmask, {rd1, rd0} & lmask);
  endtask : check_all

  task automatic apply_cfg();
    sfr_wr(ADDR_MDIN0, mdi[7:0]);
    sfr_wr(ADDR_MDIN1, mdi[15:8]);
    sfr_wr(ADDR_MDOUT0, mdo[7:0]);
    sfr_wr(ADDR_MDOUT1, mdo[15:8]);
    sfr_wr(ADDR_SKIP0, skp[7:0]);
    sfr_wr(ADDR_SKIP1, skp[15:8]);
    sfr_wr(ADDR_LATCH0, lat[7:0]);
    sfr_wr(ADDR_LATCH1, lat[15:8]);
    sfr_wr(ADDR_ROUTE0, r0);
    sfr_wr(ADDR_ROUTE1, r1);
    sfr_wr(ADDR_ROUTE2, r2);
    repeat (8) @(posedge clock);
    #DLY;
    check_all();
  endtask : apply_cfg

  task automatic rand_io();
    po = 26'($urandom);
    poe = 26'($urandom);
    lat = 16'($urandom);
    mdo = 16'($urandom);
    mdi = '1;
    skp = 16'($urandom & $urandom & $urandom);
    ext_en = 16'($urandom);
    ext_val = 16'($urandom);
    ss_mode = 2'($urandom);
  endtask : rand_io

  task automatic reg_table();
    logic [7:0] ad [10];
    logic [7:0] rv [10];
    logic [7:0] wm [10];
    logic [7:0] d, g;
    ad = '{ADDR_ROUTE0, ADDR_ROUTE1, ADDR_ROUTE2, ADDR_SKIP0, ADDR_SKIP1,
           ADDR_MDIN0, ADDR_MDIN1, ADDR_MDOUT0, ADDR_MDOUT1, 8'h33};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
           8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    wm = '{8'hFF, 8'hFF, 8'hC1, 8'hFF, 8'hFF,
           8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    for (int i = 0; i < 10; i++) begin
      sfr_rd(ad[i], g);
      cmp_reg("reset value", rv[i], g);
    end
    for (int i = 0; i < 10; i++) begin
      d = 8'($urandom);
      if (ad[i] == ADDR_ROUTE1)
        d[0] = 1'b0;
      sfr_wr(ad[i], d);
      sfr_rd(ad[i], g);
      cmp_reg("read back", d & wm[i], g);
    end
  endtask : reg_table

  initial begin : watchdog
    repeat (90000) @(posedge clock);
    fail_count++;
    print_verdict();
  end

  initial begin : main
    int i;
    void'($urandom(32'h4104));
    repeat (12) @(posedge clock);
    #DLY;
    resetn = 1'b1;
    repeat (3) @(posedge clock);
    #DLY;
    check_all();
    reg_table();
    r0 = 8'h06;
    r1 = 8'h0C;
    r2 = 8'h40;
    skp = 16'h0026;
    ss_mode = 2'b10;
    poe = '1;
    apply_cfg();
    for (i = 0; i < 8; i++) begin
      rand_io();
      r0 = 8'h01 << i;
      r1 = 8'h00;
      r2 = 8'h40;
      apply_cfg();
    end
    for (i = 0; i < 8; i++) begin
      rand_io();
      r0 = 8'h00;
      r1 = 8'hE2 | (i[7:0] << 2);
      r2 = 8'h41;
      apply_cfg();
    end
    for (i = 0; i < 40; i++) begin
      rand_io();
      r0 = 8'($urandom);
      r1 = 8'($urandom) & 8'hFE;
      r2 = 8'($urandom) & 8'hC1;
      mdi = 16'($urandom | $urandom);
      skp = skp | ~mdi;
      apply_cfg();
    end
    print_verdict();
  end
endmodule : pxb_port_crossbar_tb_top
`default_nettype wire
